// [eis_pkg.sv]
// package: constants for the enclosure identify and slot status link
package eis_pkg;
  localparam logic [7:0] EIS_ATTN_OPCODE = 8'h67;
  localparam logic [7:0] EIS_IDENTIFY_CODE = 8'hEC;
  localparam logic [7:0] EIS_SLOT_WRITE_CODE = 8'h10;
  localparam logic [7:0] EIS_KIND_SAFTE = 8'h00;
  localparam logic [7:0] EIS_KIND_SES = 8'h02;
  localparam logic [7:0] EIS_ID_LEN = 8'h40;
  localparam logic [7:0] EIS_PAGE_LAST = 8'h3F;
  localparam int EIS_SLOTS = 4;
  localparam int EIS_SLOT_BYTES = 3;
  localparam logic [7:0] EIS_SLOT_AREA = 8'h0C;
  localparam int EIS_ACT_BIT = 2;
  localparam logic [7:0] EIS_SPACE = 8'h20;
  localparam logic [7:0] EIS_ZERO = 8'h00;
  localparam logic [7:0] EIS_NAA_NIBBLE = 8'h50;
  localparam logic [7:0] EIS_OFS_SUBENC = 8'h01;
  localparam logic [7:0] EIS_OFS_LID = 8'h02;
  localparam logic [7:0] EIS_OFS_VID = 8'h0A;
  localparam logic [7:0] EIS_OFS_PID = 8'h12;
  localparam logic [7:0] EIS_OFS_PREV = 8'h22;
  localparam logic [7:0] EIS_OFS_CHAN = 8'h26;
  localparam logic [7:0] EIS_OFS_FREV = 8'h27;
  localparam logic [7:0] EIS_OFS_IFS = 8'h2B;
  localparam logic [7:0] EIS_OFS_SREV = 8'h31;
  localparam logic [7:0] EIS_OFS_VEND = 8'h35;
  // host register offsets on the apb side
  localparam logic [7:0] EIS_REG_CMD = 8'h00;
  localparam logic [7:0] EIS_REG_STAT = 8'h04;
  localparam logic [7:0] EIS_REG_WDATA = 8'h08;
  localparam logic [7:0] EIS_REG_RDATA = 8'h0C;
  localparam logic [7:0] EIS_REG_SLOT = 8'h10;
  typedef enum logic [1:0] {
    EIS_D_IDLE = 2'b00,
    EIS_D_SEND = 2'b01,
    EIS_D_RECV = 2'b10
  } eis_dstate_t;
endpackage : eis_pkg

// [eis_link_if.sv]
// interface: command and byte stream between host end and enclosure end
`timescale 1ns/1ps
`default_nettype none
interface eis_link_if;
  logic cmd_valid;
  logic [7:0] opcode;
  logic [7:0] command_code;
  logic [7:0] command_kind;
  logic [7:0] payload_length_field;
  logic cmd_ready;
  logic h2d_valid;
  logic [7:0] h2d_data;
  logic d2h_valid;
  logic [7:0] d2h_data;
  logic done;
  modport host (output cmd_valid, opcode, command_code, command_kind,
    payload_length_field, h2d_valid, h2d_data,
    input cmd_ready, d2h_valid, d2h_data, done);
  modport dev (input cmd_valid, opcode, command_code, command_kind,
    payload_length_field, h2d_valid, h2d_data,
    output cmd_ready, d2h_valid, d2h_data, done);
endinterface : eis_link_if
`default_nettype wire

// [eis_enclosure.sv]
// enclosure processor end: identify page and slot status store
`timescale 1ns/1ps
`default_nettype none
module eis_enclosure
  import eis_pkg::*;
#(
  parameter logic [63:0] LOGICAL_ID = 64'h5000_0000_0000_0001,
  parameter logic [63:0] VENDOR_STR = "VENDORX ",
  parameter logic [127:0] PRODUCT_STR = "ENCLOSURE       ",
  parameter logic [31:0] PRODUCT_REV = "0001",
  parameter logic [31:0] FIRMWARE_REV = "0100",
  parameter logic [31:0] SPEC_REV = "1.00",
  parameter logic [7:0] CHANNEL_ID = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  eis_link_if.dev link,
  output logic [EIS_SLOTS*24-1:0] slot_state,
  output logic [EIS_SLOTS-1:0] drive_activity_flag
);
  eis_dstate_t state_q;
  logic [7:0] idx_q;
  logic [7:0] len_q;
  logic ses_q;
  logic [7:0] out_q;
  logic out_v_q;
  logic done_q;
  logic [7:0] page_byte;
  logic [7:0] slot_buf_q [EIS_SLOT_BYTES];
  logic [23:0] slot_q [EIS_SLOTS];
  logic [7:0] rel;
  logic cmd_ok;
  logic kind_ok;
  // interface names held as constants so that bytes can be picked out
  localparam logic [47:0] IFS_SES = "S-E-S ";
  localparam logic [47:0] IFS_SAFTE = "SAF-TE";

  // ==========================================================
  // command decode
  // attention opcode check
  assign kind_ok = (link.command_kind == EIS_KIND_SAFTE) ||
                   (link.command_kind == EIS_KIND_SES);
  assign cmd_ok = link.cmd_valid && (link.opcode == EIS_ATTN_OPCODE) &&
                  kind_ok;
  assign link.cmd_ready = (state_q == EIS_D_IDLE);
  assign link.d2h_valid = out_v_q;
  assign link.d2h_data = out_q;
  assign link.done = done_q;

  // ==========================================================
  // identify page byte select
  // field layout by offset
  always_comb begin
    page_byte = EIS_ZERO;
    rel = EIS_ZERO;
    if (idx_q == EIS_ZERO) begin
      page_byte = EIS_ID_LEN;
    end else if (idx_q == EIS_OFS_SUBENC) begin
      page_byte = EIS_ZERO;
    end else if (idx_q < EIS_OFS_VID) begin
      rel = idx_q - EIS_OFS_LID;
      page_byte = LOGICAL_ID[8'(63 - 8*rel) -: 8];
      if (rel == EIS_ZERO)
        page_byte = {EIS_NAA_NIBBLE[7:4], LOGICAL_ID[59:56]};
    end else if (idx_q < EIS_OFS_PID) begin
      rel = idx_q - EIS_OFS_VID;
      page_byte = VENDOR_STR[8'(63 - 8*rel) -: 8];
    end else if (idx_q < EIS_OFS_PREV) begin
      rel = idx_q - EIS_OFS_PID;
      page_byte = PRODUCT_STR[8'(127 - 8*rel) -: 8];
    end else if (idx_q < EIS_OFS_CHAN) begin
      rel = idx_q - EIS_OFS_PREV;
      page_byte = PRODUCT_REV[8'(31 - 8*rel) -: 8];
    end else if (idx_q == EIS_OFS_CHAN) begin
      page_byte = CHANNEL_ID;
    end else if (idx_q < EIS_OFS_IFS) begin
      rel = idx_q - EIS_OFS_FREV;
      page_byte = FIRMWARE_REV[8'(31 - 8*rel) -: 8];
    end else if (idx_q < EIS_OFS_SREV) begin
      rel = idx_q - EIS_OFS_IFS;
      if (ses_q)
        page_byte = IFS_SES[8'(47 - 8*rel) -: 8];
      else
        page_byte = IFS_SAFTE[8'(47 - 8*rel) -: 8];
    end else if (idx_q < EIS_OFS_VEND) begin
      rel = idx_q - EIS_OFS_SREV;
      page_byte = SPEC_REV[8'(31 - 8*rel) -: 8];
    end else begin
      page_byte = EIS_ZERO;
    end
    if ((idx_q >= EIS_OFS_VID) && (idx_q < EIS_OFS_VEND) &&
        (idx_q != EIS_OFS_CHAN) &&
        ((page_byte < EIS_SPACE) || (page_byte > 8'h7E)))
      page_byte = EIS_SPACE;
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= EIS_D_IDLE;
      idx_q <= 8'h00;
      len_q <= 8'h00;
      ses_q <= 1'b0;
      out_q <= 8'h00;
      out_v_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      out_v_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        EIS_D_IDLE: begin
          idx_q <= 8'h00;
          len_q <= link.payload_length_field;
          ses_q <= (link.command_kind == EIS_KIND_SES);
          if (cmd_ok && link.command_code == EIS_IDENTIFY_CODE) begin
            state_q <= EIS_D_SEND;
          end else if (cmd_ok &&
                       link.command_code == EIS_SLOT_WRITE_CODE) begin
            state_q <= EIS_D_RECV;
          end else if (link.cmd_valid) begin
            done_q <= 1'b1; // unsupported command answered at once
          end
        end
        EIS_D_SEND: begin
          // stop at length or 64 bytes
          if (idx_q >= len_q || idx_q > EIS_PAGE_LAST) begin
            state_q <= EIS_D_IDLE;
            done_q <= 1'b1;
          end else begin
            out_q <= page_byte;
            out_v_q <= 1'b1;
            idx_q <= idx_q + 8'h01;
          end
        end
        EIS_D_RECV: begin
          if (idx_q >= len_q || idx_q > EIS_PAGE_LAST) begin
            state_q <= EIS_D_IDLE;
            done_q <= 1'b1;
          end else if (link.h2d_valid) begin
            idx_q <= idx_q + 8'h01;
          end
        end
        default: state_q <= EIS_D_IDLE;
      endcase
    end
  end

  // ==========================================================
  // slot byte gather
  // three bytes per slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < EIS_SLOT_BYTES; i++)
        slot_buf_q[i] <= 8'h00;
    end else if (state_q == EIS_D_RECV && link.h2d_valid) begin
      slot_buf_q[2'(idx_q % 8'(EIS_SLOT_BYTES))] <= link.h2d_data;
    end
  end

  // slot state store, applied on third byte of each slot unless all three bytes are zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < EIS_SLOTS; i++)
        slot_q[i] <= 24'h000000;
    end else if (state_q == EIS_D_RECV && link.h2d_valid &&
                 (idx_q % 8'(EIS_SLOT_BYTES)) == 8'h02 &&
                 idx_q < EIS_SLOT_AREA &&
                 idx_q < len_q) begin
      // bytes beyond slot area never stored
      if ({slot_buf_q[0], slot_buf_q[1], link.h2d_data} != 24'h000000)
        slot_q[2'(idx_q / 8'(EIS_SLOT_BYTES))] <=
          {slot_buf_q[0], slot_buf_q[1], link.h2d_data};
    end
  end

  // status outputs
  always_comb begin
    for (int i = 0; i < EIS_SLOTS; i++) begin
      slot_state[i*24 +: 24] = slot_q[i];
      // activity flag byte 1 bit 2
      drive_activity_flag[i] = slot_q[i][8 + EIS_ACT_BIT];
    end
  end
endmodule : eis_enclosure
`default_nettype wire

// [eis_host.sv]
// host end: apb registers driving enclosure commands
`timescale 1ns/1ps
`default_nettype none
module eis_host
  import eis_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  eis_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic busy_q;
  logic done_q;
  logic [7:0] code_q;
  logic [7:0] kind_q;
  logic [7:0] len_q;
  logic cmd_v_q;
  logic h2d_v_q;
  logic [7:0] h2d_q;
  logic [7:0] rbyte_q;
  logic rbyte_v_q;
  logic wr;
  logic rd;
  logic hit;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign hit = (paddr == EIS_REG_CMD) || (paddr == EIS_REG_STAT) ||
               (paddr == EIS_REG_WDATA) || (paddr == EIS_REG_RDATA);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ==========================================================
  // link drive
  // attention opcode always sent
  assign link.opcode = EIS_ATTN_OPCODE;
  assign link.cmd_valid = cmd_v_q;
  assign link.command_code = code_q;
  assign link.command_kind = kind_q;
  assign link.payload_length_field = len_q;
  assign link.h2d_valid = h2d_v_q;
  assign link.h2d_data = h2d_q;

  // command register: code, kind, length; start on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 8'h00;
      kind_q <= 8'h00;
      len_q <= 8'h00;
      cmd_v_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (cmd_v_q && link.cmd_ready)
        cmd_v_q <= 1'b0;
      if (link.done)
        busy_q <= 1'b0;
      if (wr && paddr == EIS_REG_CMD && !busy_q) begin
        // code, kind and length taken unchecked from bytes 0, 1 and 2
        code_q <= pwdata[7:0];
        kind_q <= pwdata[15:8];
        len_q <= pwdata[23:16];
        cmd_v_q <= 1'b1;
        busy_q <= 1'b1;
      end
    end
  end

  // software writes full slot bytes one per word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h2d_v_q <= 1'b0;
      h2d_q <= 8'h00;
    end else begin
      h2d_v_q <= wr && paddr == EIS_REG_WDATA;
      if (wr && paddr == EIS_REG_WDATA)
        h2d_q <= pwdata[7:0];
    end
  end

  // incoming identify byte and done flag; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rbyte_q <= 8'h00;
      rbyte_v_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (link.d2h_valid) begin
        rbyte_q <= link.d2h_data;
        rbyte_v_q <= 1'b1;
      end else if (rd && paddr == EIS_REG_RDATA) begin
        rbyte_v_q <= 1'b0;
      end
      if (link.done)
        done_q <= 1'b1;
      else if (wr && paddr == EIS_REG_STAT)
        done_q <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    prdata = 32'h00000000;
    if (paddr == EIS_REG_CMD)
      prdata = {8'h00, len_q, kind_q, code_q};
    else if (paddr == EIS_REG_STAT)
      prdata = {29'h0, rbyte_v_q, done_q, busy_q};
    else if (paddr == EIS_REG_RDATA)
      prdata = {24'h000000, rbyte_q};
  end
endmodule : eis_host
`default_nettype wire

// [eis_link_asserts.sv]
// checker: link properties between host end and enclosure end
`timescale 1ns/1ps
`default_nettype none
module eis_link_asserts
  import eis_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] command_code,
  input wire logic [7:0] command_kind,
  input wire logic [7:0] payload_length_field,
  input wire logic cmd_ready,
  input wire logic d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic done
);
  logic take;
  logic id_ok;
  logic [7:0] idx_q;
  logic [7:0] len_q;
  logic [47:0] ifs_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign take = cmd_valid && cmd_ready;
  assign id_ok = command_kind == EIS_KIND_SAFTE ||
                 command_kind == EIS_KIND_SES;
  // byte index within the returned page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idx_q <= 8'h00;
    else if (take) idx_q <= 8'h00;
    else if (d2h_valid) idx_q <= idx_q + 8'h01;
  end
  // capped length and expected interface string of the command taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) len_q <= 8'h00;
    else if (take)
      len_q <= (payload_length_field > EIS_ID_LEN) ? EIS_ID_LEN :
               payload_length_field;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ifs_q <= 48'h0;
    else if (take)
      ifs_q <= (command_kind == EIS_KIND_SAFTE) ? "SAF-TE" : "S-E-S ";
  end
  AST_OPCODE: assert property (cmd_valid |-> opcode == EIS_ATTN_OPCODE)
    else $error("command without attention opcode");
  // first byte leaves the register two edges after the command is taken
  AST_FIRST: assert property (take && command_code == EIS_IDENTIFY_CODE
    && id_ok && payload_length_field != 8'h00 |=> ##1
    (d2h_valid && d2h_data == EIS_ID_LEN))
    else $error("first page byte wrong or late");
  AST_BAD_KIND: assert property (take && command_code == EIS_IDENTIFY_CODE
    && !id_ok |=> done && !d2h_valid) else $error("bad kind not refused");
  AST_SUBENC: assert property (d2h_valid && idx_q == EIS_OFS_SUBENC |->
    d2h_data == EIS_ZERO) else $error("sub-enclosure byte not zero");
  AST_NAA: assert property (d2h_valid && idx_q == EIS_OFS_LID |->
    d2h_data[7:4] == 4'h5) else $error("naming authority wrong");
  AST_ASCII: assert property (d2h_valid && idx_q >= EIS_OFS_VID &&
    idx_q < EIS_OFS_VEND && idx_q != EIS_OFS_CHAN |->
    d2h_data inside {[8'h20:8'h7E]}) else $error("non-graphic string byte");
  AST_CHAN: assert property (d2h_valid && idx_q == EIS_OFS_CHAN |->
    d2h_data == EIS_ZERO) else $error("channel byte not zero");
  AST_IFS: assert property (d2h_valid && idx_q >= EIS_OFS_IFS &&
    idx_q < EIS_OFS_SREV |->
    d2h_data == ifs_q[8*(int'(EIS_OFS_SREV) - 1 - int'(idx_q)) +: 8])
    else $error("interface string wrong");
  AST_LEN: assert property (d2h_valid |-> idx_q < len_q)
    else $error("page byte beyond length");
  AST_DONE: assert property (d2h_valid && idx_q + 8'h01 == len_q |=>
    done ##1 !done) else $error("done not after last byte");
endmodule : eis_link_asserts
`default_nettype wire

// [tb.sv]
// testbench: host and enclosure ends joined, driven over apb
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eis_pkg::*;
  localparam logic [63:0] LID = 64'h5A12_3456_789A_BCDE;
  localparam logic [63:0] VID = "TESTVEND";
  localparam logic [127:0] PID = "BACKPLANE 4 BAY ";
  localparam logic [31:0] PREV = "A1B2";
  localparam logic [31:0] FREV = "0207";
  localparam logic [31:0] SREV = "1.20";
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [95:0] slot_state;
  logic [3:0] drive_activity_flag;
  logic [31:0] r;
  logic e;
  logic [7:0] cap [0:255];
  int ncap = 0;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  eis_link_if lnk ();
  eis_host i_eis_host (.clk(clk), .rst_n(rst_n), .link(lnk.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  eis_enclosure #(.LOGICAL_ID(LID), .VENDOR_STR(VID), .PRODUCT_STR(PID),
    .PRODUCT_REV(PREV), .FIRMWARE_REV(FREV), .SPEC_REV(SREV),
    .CHANNEL_ID(8'h00)) i_eis_enclosure (.clk(clk), .rst_n(rst_n),
    .link(lnk.dev), .slot_state(slot_state),
    .drive_activity_flag(drive_activity_flag));
  eis_link_asserts i_eis_link_asserts (.clk(clk), .rst_n(rst_n),
    .cmd_valid(lnk.cmd_valid), .opcode(lnk.opcode),
    .command_code(lnk.command_code), .command_kind(lnk.command_kind),
    .payload_length_field(lnk.payload_length_field),
    .cmd_ready(lnk.cmd_ready), .d2h_valid(lnk.d2h_valid),
    .d2h_data(lnk.d2h_data), .done(lnk.done));
  always #2 clk = ~clk;
  // capture returned bytes and cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (lnk.d2h_valid === 1'b1) begin
      cap[ncap] <= lnk.d2h_data;
      ncap <= ncap + 1;
    end
    if (cyc > 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // poll status until done, then clear it
  task automatic wait_done();
    for (int k = 0; k < 300; k++) begin
      apb(1'b0, EIS_REG_STAT, 32'h0);
      if (r[1] === 1'b1) break;
    end
    chk(r[1], 1'b1);
    apb(1'b1, EIS_REG_STAT, 32'h0);
  endtask : wait_done
  task automatic t_ident(input logic [7:0] kind, input logic [7:0] len);
    logic [423:0] pg;
    logic [47:0] ifs;
    int n;
    int base;
    ifs = (kind == EIS_KIND_SAFTE) ? "SAF-TE" : "S-E-S ";
    pg = {EIS_ID_LEN, EIS_ZERO, LID, VID, PID, PREV, 8'h00, FREV, ifs, SREV};
    n = (kind != EIS_KIND_SAFTE && kind != EIS_KIND_SES) ? 0 :
      (len > 8'h40) ? 64 : int'(len);
    base = ncap;
    apb(1'b1, EIS_REG_CMD, {8'h00, len, kind, EIS_IDENTIFY_CODE});
    wait_done();
    chk(ncap - base, n);
    for (int i = 0; i < 64 && i < ncap - base; i++)
      if (i < 53)
        chk(cap[base + i], pg[423-8*i -: 8]);
      else
        chk(cap[base + i], 8'h00);
  endtask : t_ident
  task automatic t_slot(input logic [119:0] b, input logic [95:0] prev,
    input logic [95:0] exp);
    // current slot state read back before the write
    chk(slot_state, prev);
    apb(1'b1, EIS_REG_CMD,
      {8'h00, 8'h0F, EIS_KIND_SAFTE, EIS_SLOT_WRITE_CODE});
    for (int i = 0; i < 15; i++)
      apb(1'b1, EIS_REG_WDATA, {24'h0, b[119-8*i -: 8]});
    wait_done();
    chk(slot_state, exp);
    for (int s = 0; s < 4; s++)
      chk(drive_activity_flag[s], exp[s*24+10]);
  endtask : t_slot
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk(slot_state, 96'h0);
    t_ident(EIS_KIND_SAFTE, 8'h40);
    t_ident(EIS_KIND_SES, 8'hC8);
    t_ident(EIS_KIND_SAFTE, 8'h2D);
    t_ident(8'h01, 8'h40);
    t_slot(120'h810402_100601_220040_000400_AABBCC, 96'h0,
      96'h000400_220040_100601_810402);
    t_slot(120'h000000_400000_000000_000404_556677,
      96'h000400_220040_100601_810402,
      96'h000404_220040_400000_810402);
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1);
    final_report();
  end
endmodule : tb
`default_nettype wire
